// File: hw/ssr_pkg.sv
/*
 Shared constants for the serial SRAM slave: opcodes, status fields,
 phase lengths and the command state type.
 Assumes it is compiled before every design file that imports it.
*/
package ssr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int MEM_DEPTH = 131072;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 25;
    localparam logic [4:0] OP_BITS = 5'h08;
    localparam logic [4:0] ADDR_BITS = 5'h18;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [1:0] IDLE_FIX_BYTES = 2'h2;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_READ2 = 8'h3B;
    localparam logic [7:0] OP_READ2A = 8'hBB;
    localparam logic [7:0] OP_READ4 = 8'h6B;
    localparam logic [7:0] OP_READ4A = 8'hEB;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_WRITE2 = 8'hA2;
    localparam logic [7:0] OP_WRITE2A = 8'h22;
    localparam logic [7:0] OP_WRITE4 = 8'h32;
    localparam logic [7:0] OP_WRITE4A = 8'hB2;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ID_RD = 8'h9F;
    localparam logic [7:0] OP_IDLE_FIX = 8'h2B;

    // ------------------------------------------------------------
    // Status register and pin reset levels
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int HOLD_DIS_BIT = 0;
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_PAGE = 2'h2;
    // sclk low, chip select high, lanes pulled high
    localparam logic [5:0] SYNC_RESET = 6'h3E;

    typedef enum {ST_OP, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP} ssr_state_t;

endpackage

// File: hw/ssr_sram_slave.sv
/*
 Serial SRAM slave: command decoder, address counter, lane shifters,
 write FIFO and 128K x 8 flip-flop array.
 Assumes the SPI pins arrive asynchronously and are oversampled by
 ref_clk_i, which must run several times faster than the serial clock.
*/
`timescale 1ns/1ns

// ------------------------------------------------------------
// Write FIFO
// ------------------------------------------------------------
module ssr_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] buf_q [0:D-1];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;

    // Full and empty from pointers with a wrap bit
    assign in_ready_o = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wp_q != rp_q;
    assign out_data_o = buf_q[rp_q[AW-1:0]];
    assign push = clk_en_i & in_valid_i & in_ready_o;
    assign pop = clk_en_i & out_valid_o & out_ready_i;

    // Pointer update
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
        end
    end

    // Storage
    always_ff @(posedge ref_clk_i) begin
        if (push) buf_q[wp_q[AW-1:0]] <= in_data_i;
    end
endmodule

// ------------------------------------------------------------
// Top
// ------------------------------------------------------------
module ssr_sram_slave #(
    parameter logic [7:0] PART_ID = 8'h5A // Arbitrary value
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic [3:0] io_lane_i,
    output logic [3:0] io_lane_o,
    output logic [3:0] io_lane_oe_o,
    output logic [7:0] operation_status_o,
    output logic overrun_o
);
    import ssr_pkg::*;

    logic [5:0] s1_q, s2_q, s3_q, f_q, agree, nf;
    logic [5:0] pin_now;
    logic rise, fall, cs_f, hold_act, quad_cmd;
    ssr_state_t state_q;
    logic [7:0] op_q, op_d, rd_q, stat_q, stat_new_q, shl;
    logic stat_pend_q, overrun_q;
    logic [23:0] sh_q, sh_n;
    logic [4:0] cnt_q, cnt_n;
    logic [1:0] nbyte_q;
    logic [ADDR_W-1:0] addr_q, addr_nx;
    logic [3:0] out_q, oe_q, drv;
    logic [2:0] w, alw, dlw;
    logic is_rd, is_wr, has_addr, has_dummy, known, byte_done;
    logic f_push, f_ready, f_valid, f_pop;
    logic [FIFO_W-1:0] f_wdata, f_rdata;
    logic [7:0] mem_q [0:MEM_DEPTH-1];

    // ------------------------------------------------------------
    // Pin synchronisers: change taken once stages two and three agree
    // ------------------------------------------------------------
    assign pin_now = {io_lane_i, chip_select_n_i, sclk_i};
    assign agree = ~(s2_q ^ s3_q);
    assign nf = (s3_q & agree) | (f_q & ~agree);
    for (genvar g = 0; g < 6; g++) begin : g_sync
        always_ff @(posedge ref_clk_i) begin
            if (!rstn_i) begin
                s1_q[g] <= SYNC_RESET[g];
                s2_q[g] <= SYNC_RESET[g];
                s3_q[g] <= SYNC_RESET[g];
                f_q[g] <= SYNC_RESET[g];
            end else if (clk_en_i) begin
                s1_q[g] <= pin_now[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                f_q[g] <= nf[g];
            end
        end
    end

    // Serial clock edges and hold qualification
    assign cs_f = f_q[1];
    assign quad_cmd = (state_q != ST_OP) && (dlw == 3'h4);
    assign hold_act = !stat_q[HOLD_DIS_BIT] && !quad_cmd && !f_q[5]
                      && !cs_f;
    assign rise = clk_en_i & nf[0] & ~f_q[0] & ~cs_f & ~hold_act;
    assign fall = clk_en_i & ~nf[0] & f_q[0] & ~hold_act;

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    assign op_d = state_q == ST_OP ? sh_n[7:0] : op_q;
    always_comb begin
        alw = 3'h1;
        dlw = 3'h1;
        is_rd = 1'b0;
        is_wr = 1'b0;
        has_addr = 1'b1;
        has_dummy = 1'b0;
        known = 1'b1;
        case (op_d)
            OP_READ: is_rd = 1'b1;
            OP_READ2: begin
                is_rd = 1'b1;
                dlw = 3'h2;
            end
            OP_READ2A: begin
                is_rd = 1'b1;
                alw = 3'h2;
                dlw = 3'h2;
                has_dummy = 1'b1;
            end
            OP_READ4: begin
                is_rd = 1'b1;
                dlw = 3'h4;
            end
            OP_READ4A: begin
                is_rd = 1'b1;
                alw = 3'h4;
                dlw = 3'h4;
                has_dummy = 1'b1;
            end
            OP_WRITE: is_wr = 1'b1;
            OP_WRITE2: begin
                is_wr = 1'b1;
                dlw = 3'h2;
            end
            OP_WRITE2A: begin
                is_wr = 1'b1;
                alw = 3'h2;
                dlw = 3'h2;
            end
            OP_WRITE4: begin
                is_wr = 1'b1;
                dlw = 3'h4;
            end
            OP_WRITE4A: begin
                is_wr = 1'b1;
                alw = 3'h4;
                dlw = 3'h4;
            end
            OP_STAT_RD, OP_ID_RD: begin
                is_rd = 1'b1;
                has_addr = 1'b0;
            end
            OP_STAT_WR, OP_IDLE_FIX: has_addr = 1'b0;
            default: known = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Input shifter: opcode always one lane, then per command
    // ------------------------------------------------------------
    assign w = state_q == ST_OP ? 3'h1 :
               state_q == ST_ADDR ? alw : dlw;
    assign cnt_n = cnt_q + {2'h0, w};
    always_comb begin
        case (w)
            3'h1: sh_n = {sh_q[22:0], f_q[2]};
            3'h2: sh_n = {sh_q[21:0], f_q[3:2]};
            default: sh_n = {sh_q[19:0], f_q[5:2]};
        endcase
    end
    assign byte_done = rise && state_q == ST_DATA && cnt_n == BYTE_BITS;

    // Next address per addressing mode
    always_comb begin
        case (stat_q[MODE_MSB:MODE_LSB])
            MODE_SEQ: addr_nx = addr_q + 17'h00001;
            MODE_PAGE: addr_nx = {addr_q[16:5], addr_q[4:0] + 5'h01};
            default: addr_nx = addr_q;
        endcase
    end

    // ------------------------------------------------------------
    // Command sequencer on rising serial clock
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_q <= ST_OP;
            cnt_q <= '0;
            sh_q <= '0;
            op_q <= '0;
            addr_q <= '0;
            rd_q <= '0;
            nbyte_q <= '0;
        end else if (clk_en_i && cs_f) begin
            state_q <= ST_OP;
            cnt_q <= '0;
        end else if (rise) begin
            sh_q <= sh_n;
            cnt_q <= cnt_n;
            case (state_q)
                ST_OP: if (cnt_n == OP_BITS) begin
                    op_q <= op_d;
                    cnt_q <= '0;
                    nbyte_q <= '0;
                    rd_q <= op_d == OP_STAT_RD ? stat_q : PART_ID;
                    state_q <= !known ? ST_SKIP :
                               has_addr ? ST_ADDR : ST_DATA;
                end
                ST_ADDR: if (cnt_n == ADDR_BITS) begin
                    addr_q <= sh_n[ADDR_W-1:0];
                    rd_q <= mem_q[sh_n[ADDR_W-1:0]];
                    cnt_q <= '0;
                    state_q <= has_dummy ? ST_DUMMY : ST_DATA;
                end
                ST_DUMMY: if (cnt_n == BYTE_BITS) begin
                    cnt_q <= '0;
                    state_q <= ST_DATA;
                end
                ST_DATA: if (cnt_n == BYTE_BITS) begin
                    cnt_q <= '0;
                    nbyte_q <= nbyte_q + 2'h1;
                    if (has_addr) begin
                        addr_q <= addr_nx;
                        rd_q <= mem_q[addr_nx];
                    end
                    if (op_q == OP_IDLE_FIX &&
                        nbyte_q + 2'h1 == IDLE_FIX_BYTES) begin
                        state_q <= ST_SKIP;
                    end
                end
                default: cnt_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status register: written byte lands on the next falling edge
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            stat_q <= STATUS_RESET;
            stat_pend_q <= 1'b0;
            stat_new_q <= '0;
        end else if (byte_done && op_q == OP_STAT_WR) begin
            stat_pend_q <= 1'b1;
            stat_new_q <= sh_n[7:0];
        end else if (stat_pend_q && (fall || (clk_en_i && cs_f))) begin
            stat_q <= stat_new_q;
            stat_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output lanes change on falling serial clock
    // ------------------------------------------------------------
    assign shl = rd_q << cnt_q[2:0];
    always_comb begin
        case (dlw)
            3'h1: drv = 4'h2;
            3'h2: drv = 4'h3;
            default: drv = 4'hF;
        endcase
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            out_q <= '0;
            oe_q <= '0;
        end else if (clk_en_i && cs_f) begin
            oe_q <= '0;
        end else if (fall) begin
            oe_q <= state_q == ST_DATA && is_rd ? drv : 4'h0;
            case (dlw)
                3'h1: out_q <= {2'h0, shl[7], 1'b0};
                3'h2: out_q <= {2'h0, shl[7:6]};
                default: out_q <= shl[7:4];
            endcase
        end
    end
    assign io_lane_o = out_q;
    assign io_lane_oe_o = oe_q & {4{~cs_f & ~hold_act}};
    assign operation_status_o = stat_q;
    assign overrun_o = overrun_q;

    // ------------------------------------------------------------
    // Write path: whole bytes only, through the FIFO to the array
    // ------------------------------------------------------------
    assign f_push = byte_done && is_wr;
    assign f_wdata = {addr_q, sh_n[7:0]};
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) overrun_q <= 1'b0;
        else if (f_push && !f_ready) overrun_q <= 1'b1;
    end

    ssr_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) ssr_fifo_i (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(f_push),
        .in_ready_o(f_ready),
        .in_data_i(f_wdata),
        .out_valid_o(f_valid),
        .out_ready_i(!rise),
        .out_data_o(f_rdata)
    );

    // Array port is lent to read fetches on rising edges
    assign f_pop = clk_en_i && f_valid && !rise;
    always_ff @(posedge ref_clk_i) begin
        if (f_pop) mem_q[f_rdata[FIFO_W-1:8]] <= f_rdata[7:0];
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_addr_end;
        rise && state_q == ST_ADDR && cnt_n == ADDR_BITS && has_dummy;
    endsequence
    sequence s_read_fall;
        fall && !cs_f && state_q == ST_DATA && is_rd;
    endsequence

    property p_deselect;
        clk_en_i && cs_f |=> state_q == ST_OP && oe_q == 4'h0;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselect did not end the command");
    property p_byte_mode;
        byte_done && stat_q[7:6] == MODE_BYTE |=> $stable(addr_q);
    endproperty
    a_byte_mode: assert property (p_byte_mode)
        else $error("byte mode address moved");
    property p_page;
        byte_done && stat_q[7:6] == MODE_PAGE && has_addr |=>
            addr_q[16:5] == $past(addr_q[16:5]) &&
            addr_q[4:0] == $past(addr_q[4:0]) + 5'h01;
    endproperty
    a_page: assert property (p_page)
        else $error("page mode address wrong");
    property p_seq;
        byte_done && stat_q[7:6] == MODE_SEQ && has_addr |=>
            addr_q == $past(addr_q) + 17'h00001;
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequential address wrong");
    property p_hold;
        hold_act ##1 !cs_f |-> $stable(addr_q) && $stable(cnt_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold did not freeze transfer");
    property p_dummy;
        s_addr_end |=> state_q == ST_DUMMY ##1 io_lane_oe_o == 4'h0;
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("lanes driven in dummy period");
    property p_quad;
        s_read_fall ##0 dlw == 3'h4 |=> oe_q == 4'hF;
    endproperty
    a_quad: assert property (p_quad)
        else $error("quad read not on four lanes");
    property p_dual;
        s_read_fall ##0 dlw == 3'h2 |=> oe_q == 4'h3;
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual read not on two lanes");
    property p_opcode;
        rise && state_q == ST_OP |=>
            cnt_q == $past(cnt_q) + 5'h01 || state_q != ST_OP;
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("opcode not one bit per clock");
    property p_stat_wr;
        stat_pend_q && fall |=> stat_q == $past(stat_new_q);
    endproperty
    a_stat_wr: assert property (p_stat_wr)
        else $error("status write not applied");
endmodule

// File: tb/ssr_host_model.sv
/*
 SPI host model for the serial SRAM slave, mode 0, 125 ns serial clock.
 Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ns
module ssr_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] lane_o,
    input wire logic [3:0] dev_lane_i,
    input wire logic [3:0] dev_oe_i
);
    logic [3:0] hv;
    logic [3:0] hoe;
    logic [3:0] oe_acc;
    logic hold;

    // Idle: deselected, serial clock resting low
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        hv = 4'h0;
        hoe = 4'h0;
        hold = 1'b0;
    end

    // Wire level: device, host, pull-up on 2/3, else inverse of last
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (dev_oe_i[k]) lane_o[k] = dev_lane_i[k];
            else if (hoe[k]) lane_o[k] = hv[k];
            else lane_o[k] = (k > 1) ? 1'b1 : ~hv[k];
        end
    end

    // Frame opens with select low and closes with select high
    task automatic frame_start();
        #37 cs_n_o = 1'b0;
        #70;
    endtask
    task automatic frame_end();
        #70 cs_n_o = 1'b1;
        hoe = 4'h0;
        #110;
    endtask

    // n clocks of w lanes, MSB first, lane 0 lowest; set while sclk low,
    // sampled at the rise; single-lane data returns on lane 1
    task automatic shift(input int w, input int n, input logic [31:0] wd,
        input bit drv, output logic [31:0] rd);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        rd = 32'h0;
        oe_acc = 4'h0;
        for (int i = n - 1; i >= 0; i--) begin
            #20;
            hv = 4'(wd >> (i * w)) & m;
            hoe = drv ? m : 4'h0;
            if (hold) begin
                hv[3] = 1'b0;
                hoe[3] = 1'b1;
            end
            #50 sclk_o = 1'b1;
            rd = (rd << w) | ((w == 1) ? 32'(lane_o[1]) : 32'(lane_o & m));
            oe_acc = oe_acc | dev_oe_i;
            #55 sclk_o = 1'b0;
        end
    endtask
endmodule

// File: tb/ssr_sram_slave_tb.sv
/*
 Self-checking bench for the serial SRAM slave, one task per scenario.
 Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end
module ssr_sram_slave_tb;
    import ssr_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
    logic ref_clk_i;
    logic rstn_i;
    logic clk_en_i;
    logic sclk;
    logic cs_n;
    logic [3:0] lane_in;
    logic [3:0] lane_out;
    logic [3:0] lane_oe;
    logic [7:0] status;
    logic overrun;
    int num_errors = 0;
    int n_compared = 0;

    ssr_sram_slave #(.PART_ID(ID_VAL)) ssr_sram_slave_i (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sclk_i(sclk),
        .chip_select_n_i(cs_n),
        .io_lane_i(lane_in),
        .io_lane_o(lane_out),
        .io_lane_oe_o(lane_oe),
        .operation_status_o(status),
        .overrun_o(overrun)
    );
    ssr_host_model ssr_host_model_i (
        .sclk_o(sclk),
        .cs_n_o(cs_n),
        .lane_o(lane_in),
        .dev_lane_i(lane_out),
        .dev_oe_i(lane_oe)
    );

    // ------------------------------------------------------------
    // Shared link tasks
    // ------------------------------------------------------------
    task automatic sh(input int w, input int n, input logic [31:0] wd,
        input bit d, output logic [31:0] rd);
        ssr_host_model_i.shift(w, n, wd, d, rd);
    endtask

    // One frame; only listed opcodes are ever sent
    task automatic acc(input logic [7:0] op, input int aw, dw, dum,
        input logic [23:0] a, input int nb, input logic [31:0] wd,
        input bit d, output logic [31:0] rd);
        ssr_host_model_i.frame_start();
        sh(1, 8, 32'(op), 1'b1, rd);
        if (aw > 0) sh(aw, 24 / aw, 32'(a), 1'b1, rd);
        if (dum > 0) begin
            sh(dw, dum, 32'h0, 1'b0, rd);
            `CHK(ssr_host_model_i.oe_acc, 4'h0)
        end
        sh(dw, nb * 8 / dw, wd, d, rd);
        ssr_host_model_i.frame_end();
    endtask

    task automatic setst(input logic [7:0] v);
        logic [31:0] rd;
        acc(OP_STAT_WR, 0, 1, 0, 24'h0, 1, 32'(v), 1'b1, rd);
        `CHK(status, v)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_ids();
        logic [31:0] rd;
        `CHK(status, STATUS_RESET)
        acc(OP_STAT_RD, 0, 1, 0, 24'h0, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], 16'h0000)
        acc(OP_ID_RD, 0, 1, 0, 24'h0, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], ({ID_VAL, ID_VAL}))
        `CHK(lane_oe, 4'h0)
    endtask

    task automatic t_status();
        logic [31:0] rd;
        setst(8'h81);
        ssr_host_model_i.frame_start();
        sh(1, 8, 32'(OP_STAT_WR), 1'b1, rd);
        sh(1, 5, 32'h0, 1'b1, rd);
        ssr_host_model_i.frame_end();
        `CHK(status, 8'h81)
        acc(OP_IDLE_FIX, 0, 1, 0, 24'h0, 2, 32'h1000, 1'b1, rd);
        `CHK(status, 8'h81)
        // Clock enable low: whole frames must leave no trace
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        acc(OP_STAT_WR, 0, 1, 0, 24'h0, 1, 32'h0, 1'b1, rd);
        `CHK(status, 8'h81)
        acc(OP_STAT_RD, 0, 1, 0, 24'h0, 1, 32'h0, 1'b0, rd);
        `CHK(ssr_host_model_i.oe_acc, 4'h0)
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
    endtask

    task automatic t_byte();
        logic [31:0] rd;
        setst(8'h00);
        acc(OP_WRITE, 1, 1, 0, 24'h000010, 2, 32'h1122, 1'b1, rd);
        acc(OP_READ, 1, 1, 0, 24'h000010, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], 16'h2222)
    endtask

    task automatic t_seq();
        logic [31:0] rd;
        setst(8'h40);
        acc(OP_WRITE4A, 4, 4, 0, 24'hFFFFFF, 2, 32'hA1B2, 1'b1, rd);
        acc(OP_READ2A, 2, 2, 4, 24'h01FFFF, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], 16'hA1B2)
        acc(OP_READ2, 1, 2, 0, 24'hFE0000, 1, 32'h0, 1'b0, rd);
        `CHK(rd[7:0], 8'hB2)
    endtask

    task automatic t_page();
        logic [31:0] rd;
        setst(8'h80);
        acc(OP_WRITE2A, 2, 2, 0, 24'h00013F, 2, 32'h5C6D, 1'b1, rd);
        acc(OP_READ4A, 4, 4, 2, 24'h00013F, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], 16'h5C6D)
        acc(OP_WRITE2, 1, 2, 0, 24'h000150, 1, 32'h9E, 1'b1, rd);
        acc(OP_WRITE4, 1, 4, 0, 24'h000151, 1, 32'h4F, 1'b1, rd);
        acc(OP_READ4, 1, 4, 0, 24'h000150, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], 16'h9E4F)
    endtask

    task automatic t_partial();
        logic [31:0] rd;
        setst(8'h40);
        acc(OP_WRITE, 1, 1, 0, 24'h000200, 2, 32'h0055, 1'b1, rd);
        ssr_host_model_i.frame_start();
        sh(1, 8, 32'(OP_WRITE), 1'b1, rd);
        sh(1, 24, 32'h000200, 1'b1, rd);
        sh(1, 12, 32'h77A, 1'b1, rd);
        ssr_host_model_i.frame_end();
        acc(OP_READ, 1, 1, 0, 24'h000200, 2, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], 16'h7755)
    endtask

    // Single read at 200h with hold low for the middle four clocks
    task automatic hold_rd(output logic [7:0] paused,
        output logic [7:0] run, output logic oe_h);
        logic [31:0] a, h, c;
        ssr_host_model_i.frame_start();
        sh(1, 8, 32'(OP_READ), 1'b1, a);
        sh(1, 24, 32'h200, 1'b1, a);
        sh(1, 4, 32'h0, 1'b0, a);
        ssr_host_model_i.hold = 1'b1;
        sh(1, 4, 32'h0, 1'b0, h);
        oe_h = ssr_host_model_i.oe_acc[1];
        ssr_host_model_i.hold = 1'b0;
        sh(1, 4, 32'h0, 1'b0, c);
        ssr_host_model_i.frame_end();
        paused = {a[3:0], c[3:0]};
        run = {a[3:0], h[3:0]};
    endtask

    task automatic t_hold();
        logic [7:0] p, r;
        logic o;
        hold_rd(p, r, o);
        `CHK(p, 8'h77)
        `CHK(o, 1'b0)
        setst(8'h41);
        hold_rd(p, r, o);
        `CHK(r, 8'h77)
    endtask

    // ------------------------------------------------------------
    // Clock, run and verdict
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Watchdog well beyond the expected run of some 27 frames
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end

    // Reset, then the scenarios in order
    initial begin
        rstn_i = 1'b0;
        clk_en_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        t_ids();
        t_status();
        t_byte();
        t_seq();
        t_page();
        t_partial();
        t_hold();
        `CHK(overrun, 1'b0)
        summarize();
    end
endmodule
